// [rtl/mat_top.sv]
// Purpose: instruction_translation_unit and data_translation_unit with shared table walker
// Assumes: One memory port for table walks; requester holds nothing after acceptance
// Notes:   Side 0 is instruction, side 1 is data
// Functional notes
// - Each buffer holds 64 sets of two ways, LRU way replaced.
// - Separate buffers for instruction side and data side.
// - On a miss, walk the hashed page table and fill from the hit.
// - Page translation replaces address bits 31..12, keeps 11..0.
// - A full 32-bit physical address is returned.
// - Requester gives side, privilege and load/store; used for steering and protection.
// - Pages are 4 KB; blocks span 128 KB to 256 MB.
// - Relocation off means physical equals effective, other paths ignored.
// - Instruction and data relocation enables are independent.
// - Top four address bits select one of 16 segment descriptors.
// - Direct-store segment gives the storage exception of that side.
// - Block match overrides the parallel page result.
// - At least 17 low bits stay untranslated inside a block.
// - Supervisor-only pages refuse user accesses.
// - No-execute segments refuse fetches only.
// - Guarded memory is never accessed speculatively.
// - Walk for load or fetch sets a clear referenced bit.
// - Walk for store sets referenced and changed if either is clear.
// - Store hit with clear changed bit sets it in buffer and table.
// - Protection violation raises that side's storage exception.
// - No block match and no table entry raises a page fault.
`timescale 1ns/1ps
module mat_top
  import mat_pkg::*;
(
  input  wire logic        clk_sys_in,        // 20 MHz system clock
  input  wire logic        rst_n_in,          // Synchronous reset, active low
  input  wire logic        psel_in,           // APB select
  input  wire logic        penable_in,        // APB access phase
  input  wire logic        pwrite_in,         // APB write
  input  wire logic [11:0] paddr_in,          // APB byte address
  input  wire logic [31:0] pwdata_in,         // APB write data
  output logic             pready_out,        // APB ready
  output logic      [31:0] prdata_out,        // APB read data
  output logic             pslverr_out,       // APB error, unmapped address
  input  wire logic [1:0]  req_valid_in,      // Request valid, [0] fetch, [1] data
  input  mat_req_t         req_in [2],        // Request per side
  output logic      [1:0]  req_ready_out,     // Side can take a request
  output logic      [1:0]  resp_valid_out,    // One-cycle answer strobe
  output mat_resp_t        resp_out [2],      // Answer per side
  output logic             mem_req_out,       // Table memory request
  output logic             mem_we_out,        // Table memory write
  output logic      [31:0] mem_addr_out,      // Table word address
  output logic      [31:0] mem_wdata_out,     // Table write data
  input  wire logic        mem_ack_in,        // Table memory done
  input  wire logic [31:0] mem_rdata_in       // Table read data
);
  typedef enum {W_IDLE, W_RD0, W_RD1, W_WR, W_FILL} mat_wstate_t;

  // Register decode shared by the read and write paths
  function automatic logic mat_is_seg(input logic [11:0] a);
    return a[11:6] == MAT_SEG_OFS[11:6];
  endfunction
  function automatic logic mat_is_bat(input logic [11:0] a);
    return a[11:6] == MAT_BAT_OFS[11:6];
  endfunction

  logic [1:0]  ctrl_q;
  logic [31:0] htab_q;
  logic [31:0] fault_ea_q;
  logic [31:0] seg_q [MAT_SEGS];
  logic [31:0] bat_q [2*MAT_BATS*2];
  logic        tlb_v_q [2][MAT_SETS][MAT_WAYS];
  mat_tlbe_t   tlb_q [2][MAT_SETS][MAT_WAYS];
  logic        lru_q [2][MAT_SETS];
  logic [1:0]  busy_q, wait_q, grant;
  mat_req_t    hold_q [2];
  logic [1:0]  done_c, walk_c, cupd_c, hit_c, hway_c;
  mat_resp_t   res_c [2];
  logic [31:0] hit_addr_c [2];
  mat_wstate_t wst_q;
  logic        wk_side_q, wk_cupd_q, wk_way_q, wk_fault_q, wk_done_q, req_q;
  mat_req_t    wk_req_q;
  logic [23:0] wk_vsid_q;
  logic [31:0] wk_base_q, wk_w1_q;
  logic [2:0]  wk_k_q;
  logic        wr_en, mapped;
  logic [18:0] hash;

  // APB: zero wait states, read data caught in the setup cycle
  assign wr_en       = psel_in & penable_in & pwrite_in;
  assign pready_out  = 1'b1;
  assign mapped      = mat_is_seg(paddr_in) | mat_is_bat(paddr_in) | (paddr_in <= MAT_INVAL_OFS);
  assign pslverr_out = psel_in & penable_in & ~mapped;

  // Register writes
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ctrl_q <= MAT_CTRL_RST;
      htab_q <= MAT_HTAB_RST;
      for (int i = 0; i < MAT_SEGS; i++) seg_q[i] <= 32'h0;
      for (int i = 0; i < 4*MAT_BATS; i++) bat_q[i] <= 32'h0;
    end else if (wr_en) begin
      if (paddr_in == MAT_CTRL_OFS) ctrl_q <= pwdata_in[1:0];
      if (paddr_in == MAT_HTAB_OFS) htab_q <= pwdata_in;
      if (mat_is_seg(paddr_in)) seg_q[paddr_in[5:2]] <= pwdata_in;
      if (mat_is_bat(paddr_in)) bat_q[paddr_in[5:2]] <= pwdata_in;
    end
  end

  // Read data register
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0;
    end else if (psel_in & ~penable_in & ~pwrite_in) begin
      prdata_out <= 32'h0;
      if (paddr_in == MAT_CTRL_OFS) prdata_out <= {30'h0, ctrl_q};
      if (paddr_in == MAT_HTAB_OFS) prdata_out <= htab_q;
      if (paddr_in == MAT_STATUS_OFS) prdata_out <= {27'h0, wait_q, busy_q, wst_q != W_IDLE};
      if (paddr_in == MAT_FLTEA_OFS) prdata_out <= fault_ea_q;
      if (mat_is_seg(paddr_in)) prdata_out <= seg_q[paddr_in[5:2]];
      if (mat_is_bat(paddr_in)) prdata_out <= bat_q[paddr_in[5:2]];
    end
  end

  // Per-side lookup and request holding, two independent buffers
  for (genvar s = 0; s < 2; s++) begin : g_side
    mat_req_t    r;
    logic [31:0] sd, bu, bl;
    logic        en, bhit, key, no_acc, ro, viol, g;
    logic [33:0] tag;
    logic [5:0]  set;
    logic [14:0] bmask;
    mat_tlbe_t   e;

    assign r   = hold_q[s];
    assign en  = ctrl_q[s == 0 ? MAT_CTRL_IR_BIT : MAT_CTRL_DR_BIT];
    assign sd  = seg_q[r.ea[31:28]];
    assign set = r.ea[17:12];
    assign tag = {sd[23:0], r.ea[27:18]};

    // Lookup, resolution in fixed priority order
    always_comb begin
      bhit   = 1'b0;
      bu     = 32'h0;
      bl     = 32'h0;
      hit_c[s] = 1'b0;
      hway_c[s] = 1'b0;
      e      = tlb_q[s][set][0];
      for (int k = MAT_BATS - 1; k >= 0; k--) begin
        // Mask bits 12..2 open 128 KB up to 256 MB; bits 16..0 never translate
        if (((bat_q[2*(s*MAT_BATS+k)][31:17] ^ r.ea[31:17]) &
             ~{4'h0, bat_q[2*(s*MAT_BATS+k)][12:2]}) == 15'h0 &&
            bat_q[2*(s*MAT_BATS+k)][r.user ? MAT_BAT_VP_BIT : MAT_BAT_VS_BIT]) begin
          bhit = 1'b1;
          bu   = bat_q[2*(s*MAT_BATS+k)];
          bl   = bat_q[2*(s*MAT_BATS+k)+1];
        end
      end
      for (int w = MAT_WAYS - 1; w >= 0; w--) begin
        if (tlb_v_q[s][set][w] && tlb_q[s][set][w].tag == tag) begin
          hit_c[s]  = 1'b1;
          hway_c[s] = w[0];
          e         = tlb_q[s][set][w];
        end
      end
      bmask = {4'h0, bu[12:2]};
      key   = r.user ? sd[MAT_SEG_KP_BIT] : sd[MAT_SEG_KS_BIT];
      no_acc = bhit ? bl[1:0] == 2'h0 : key & (e.pp == 2'h0);
      ro    = bhit ? bl[0] : (e.pp == 2'h3) | (key & e.pp == 2'h1);
      viol  = no_acc | (r.store & ro);
      g     = bhit ? bl[MAT_BAT_G_BIT] : e.g;
      done_c[s] = 1'b1;
      walk_c[s] = 1'b0;
      cupd_c[s] = 1'b0;
      hit_addr_c[s] = e.pte_addr;
      res_c[s].block = 1'b0;
      res_c[s].exc   = MAT_OK;
      res_c[s].pa    = r.ea;
      if (!en) begin
        res_c[s].pa = r.ea;
      end else if (bhit) begin
        res_c[s].block = 1'b1;
        res_c[s].pa = {(bl[31:17] & ~bmask) | (r.ea[31:17] & bmask), r.ea[16:0]};
      end else if (sd[MAT_SEG_T_BIT]) begin
        res_c[s].exc = MAT_DSTORE;
      end else if (s == 0 && sd[MAT_SEG_N_BIT]) begin
        res_c[s].exc = MAT_NOEXEC;
      end else if (hit_c[s]) begin
        res_c[s].pa = {e.rpn, r.ea[11:0]};
        if (r.store && !e.c && !viol && !(g && r.spec)) begin
          done_c[s] = 1'b0;
          walk_c[s] = 1'b1;
          cupd_c[s] = 1'b1;
        end
      end else begin
        done_c[s] = 1'b0;
        walk_c[s] = 1'b1;
      end
      // Protection applies to block and page results alike
      if (en && res_c[s].exc == MAT_OK && (bhit || hit_c[s])) begin
        if (viol) begin
          res_c[s].exc = MAT_PROT;
        end else if (g && s == 0) begin
          res_c[s].exc = MAT_GUARD;
        end else if (g && r.spec) begin
          res_c[s].exc = MAT_DEFER;
        end
        if (res_c[s].exc != MAT_OK) begin
          done_c[s] = 1'b1;
          walk_c[s] = 1'b0;
          cupd_c[s] = 1'b0;
        end
      end
    end

    assign req_ready_out[s] = ~busy_q[s];

    // Request holding, answer strobe and walk waiting
    always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
        busy_q[s]         <= 1'b0;
        wait_q[s]         <= 1'b0;
        resp_valid_out[s] <= 1'b0;
        hold_q[s]         <= '0;
        resp_out[s]       <= '0;
      end else begin
        resp_valid_out[s] <= 1'b0;
        if (!busy_q[s]) begin
          if (req_valid_in[s]) begin
            busy_q[s] <= 1'b1;
            hold_q[s] <= req_in[s];
            if (s == 0) hold_q[s].store <= 1'b0;
          end
        end else if (wait_q[s]) begin
          if (wk_done_q && wk_side_q == s[0]) begin
            wait_q[s] <= 1'b0;
            if (wk_fault_q) begin
              busy_q[s]         <= 1'b0;
              resp_valid_out[s] <= 1'b1;
              resp_out[s]       <= '{pa: hold_q[s].ea, exc: MAT_PAGE_FAULT, block: 1'b0};
            end
          end
        end else if (done_c[s]) begin
          busy_q[s]         <= 1'b0;
          resp_valid_out[s] <= 1'b1;
          resp_out[s]       <= res_c[s];
        end else if (grant[s]) begin
          wait_q[s] <= 1'b1;
        end
      end
    end
  end

  // Walker arbitration, data side first since stores stall retirement
  always_comb begin
    grant = 2'b00;
    if (wst_q == W_IDLE) begin
      if (busy_q[1] & ~wait_q[1] & walk_c[1]) grant = 2'b10;
      else if (busy_q[0] & ~wait_q[0] & walk_c[0]) grant = 2'b01;
    end
  end

  // Primary hash over the segment identity and page index
  assign hash = wk_vsid_q[18:0] ^ {3'h0, wk_req_q.ea[27:12]};

  // Table walker and its memory port
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wst_q <= W_IDLE;
      {wk_side_q, wk_cupd_q, wk_way_q, wk_fault_q, wk_done_q, req_q} <= 6'h0;
      wk_req_q  <= '0;
      wk_vsid_q <= 24'h0;
      wk_base_q <= 32'h0;
      wk_w1_q   <= 32'h0;
      wk_k_q    <= 3'h0;
      mem_we_out    <= 1'b0;
      mem_addr_out  <= 32'h0;
      mem_wdata_out <= 32'h0;
    end else begin
      wk_done_q <= 1'b0;
      case (wst_q)
        W_IDLE: begin
          if (grant != 2'b00) begin
            wk_side_q  <= grant[1];
            wk_req_q   <= hold_q[grant[1]];
            wk_vsid_q  <= seg_q[hold_q[grant[1]].ea[31:28]][23:0];
            wk_cupd_q  <= cupd_c[grant[1]];
            wk_way_q   <= hway_c[grant[1]];
            wk_base_q  <= hit_addr_c[grant[1]] - 32'h4;
            wk_k_q     <= 3'h0;
            wk_fault_q <= 1'b0;
            wst_q      <= cupd_c[grant[1]] ? W_RD1 : W_RD0;
          end
        end
        W_RD0: begin
          if (!req_q) begin
            req_q        <= 1'b1;
            mem_we_out   <= 1'b0;
            mem_addr_out <= {htab_q[31:16], 16'h0} | {7'h0, hash & {htab_q[8:0], 10'h3ff}, 6'h0}
                            | {26'h0, wk_k_q, 3'h0};
          end else if (mem_ack_in) begin
            req_q <= 1'b0;
            if (mem_rdata_in[MAT_PTE_V_BIT] && mem_rdata_in[30:7] == wk_vsid_q &&
                !mem_rdata_in[6] && mem_rdata_in[5:0] == wk_req_q.ea[27:22]) begin
              wk_base_q <= mem_addr_out;
              wst_q     <= W_RD1;
            end else if (wk_k_q == 3'(MAT_GROUP_PTES - 1)) begin
              wk_fault_q <= 1'b1;
              wk_done_q  <= 1'b1;
              wst_q      <= W_IDLE;
            end else begin
              wk_k_q <= wk_k_q + 3'h1;
            end
          end
        end
        W_RD1: begin
          if (!req_q) begin
            req_q        <= 1'b1;
            mem_we_out   <= 1'b0;
            mem_addr_out <= wk_base_q + 32'h4;
          end else if (mem_ack_in) begin
            req_q   <= 1'b0;
            wk_w1_q <= mem_rdata_in | {23'h0, 1'b1, wk_req_q.store, 7'h0};
            if (!mem_rdata_in[MAT_PTE_R_BIT] || (wk_req_q.store && !mem_rdata_in[MAT_PTE_C_BIT]))
              wst_q <= W_WR;
            else
              wst_q <= W_FILL;
          end
        end
        W_WR: begin
          if (!req_q) begin
            req_q         <= 1'b1;
            mem_we_out    <= 1'b1;
            mem_wdata_out <= wk_w1_q;
          end else if (mem_ack_in) begin
            req_q      <= 1'b0;
            mem_we_out <= 1'b0;
            wst_q      <= W_FILL;
          end
        end
        W_FILL: begin
          wk_done_q <= 1'b1;
          wst_q     <= W_IDLE;
        end
        default: wst_q <= W_IDLE;
      endcase
    end
  end
  assign mem_req_out = req_q;

  // Buffer fill, changed-bit update, LRU and invalidation
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      for (int s = 0; s < 2; s++)
        for (int i = 0; i < MAT_SETS; i++) begin
          lru_q[s][i] <= 1'b0;
          for (int w = 0; w < MAT_WAYS; w++) tlb_v_q[s][i][w] <= 1'b0;
        end
    end else begin
      for (int s = 0; s < 2; s++)
        if (busy_q[s] & ~wait_q[s] & done_c[s] & hit_c[s])
          lru_q[s][hold_q[s].ea[17:12]] <= ~hway_c[s];
      if (wst_q == W_FILL) begin
        if (wk_cupd_q) begin
          tlb_q[wk_side_q][wk_req_q.ea[17:12]][wk_way_q].c <= 1'b1;
        end else begin
          tlb_v_q[wk_side_q][wk_req_q.ea[17:12]][lru_q[wk_side_q][wk_req_q.ea[17:12]]] <= 1'b1;
          tlb_q[wk_side_q][wk_req_q.ea[17:12]][lru_q[wk_side_q][wk_req_q.ea[17:12]]] <=
            '{tag: {wk_vsid_q, wk_req_q.ea[27:18]}, rpn: wk_w1_q[31:12], pp: wk_w1_q[1:0],
              g: wk_w1_q[MAT_PTE_G_BIT], c: wk_w1_q[MAT_PTE_C_BIT], pte_addr: wk_base_q + 32'h4};
          lru_q[wk_side_q][wk_req_q.ea[17:12]] <= ~lru_q[wk_side_q][wk_req_q.ea[17:12]];
        end
      end
      // Invalidate one set in both buffers; overrides a fill of the same set
      if (wr_en && paddr_in == MAT_INVAL_OFS)
        for (int s = 0; s < 2; s++)
          for (int w = 0; w < MAT_WAYS; w++) tlb_v_q[s][pwdata_in[17:12]][w] <= 1'b0;
    end
  end

  // Last faulting address, for software diagnosis
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      fault_ea_q <= 32'h0;
    end else begin
      for (int s = 0; s < 2; s++)
        if (resp_valid_out[s] && resp_out[s].exc != MAT_OK) fault_ea_q <= hold_q[s].ea;
    end
  end
endmodule

// [rtl/mat_pkg.sv]
// Purpose: Shared constants and types for the address translation block
// Assumes: APB register access, 32-bit words, bit 31 is the most significant bit
// Notes:   Entry formats are local to this block, not the memory table layout
package mat_pkg;
  // Register byte offsets
  localparam logic [11:0] MAT_CTRL_OFS    = 12'h000;
  localparam logic [11:0] MAT_HTAB_OFS    = 12'h004;
  localparam logic [11:0] MAT_STATUS_OFS  = 12'h008;
  localparam logic [11:0] MAT_FLTEA_OFS   = 12'h00c;
  localparam logic [11:0] MAT_INVAL_OFS   = 12'h010;
  localparam logic [11:0] MAT_SEG_OFS     = 12'h040;
  localparam logic [11:0] MAT_BAT_OFS     = 12'h080;
  // Control field positions and reset value
  localparam int          MAT_CTRL_IR_BIT = 0;
  localparam int          MAT_CTRL_DR_BIT = 1;
  localparam logic [1:0]  MAT_CTRL_RST    = 2'h0;
  localparam logic [31:0] MAT_HTAB_RST    = 32'h0000_0000;
  // Segment descriptor fields
  localparam int          MAT_SEG_T_BIT   = 31;
  localparam int          MAT_SEG_KS_BIT  = 30;
  localparam int          MAT_SEG_KP_BIT  = 29;
  localparam int          MAT_SEG_N_BIT   = 28;
  // Block entry fields: upper word and lower word
  localparam int          MAT_BAT_VS_BIT  = 1;
  localparam int          MAT_BAT_VP_BIT  = 0;
  localparam int          MAT_BAT_G_BIT   = 3;
  // Table entry word fields
  localparam int          MAT_PTE_V_BIT   = 31;
  localparam int          MAT_PTE_R_BIT   = 8;
  localparam int          MAT_PTE_C_BIT   = 7;
  localparam int          MAT_PTE_G_BIT   = 3;
  // Geometry
  localparam int          MAT_SETS        = 64;
  localparam int          MAT_WAYS        = 2;
  localparam int          MAT_BATS        = 4;
  localparam int          MAT_SEGS        = 16;
  localparam int          MAT_GROUP_PTES  = 8;

  typedef enum logic [2:0] {
    MAT_OK, MAT_PAGE_FAULT, MAT_PROT, MAT_DSTORE, MAT_NOEXEC, MAT_GUARD, MAT_DEFER
  } mat_exc_t;

  typedef struct packed {
    logic [31:0] ea;     // effective_address
    logic        user;   // problem_state_flag of the access
    logic        store;  // data store, zero for loads and fetches
    logic        spec;   // speculative or out-of-order access
  } mat_req_t;

  typedef struct packed {
    logic [31:0] pa;     // physical_address
    mat_exc_t    exc;
    logic        block;  // translated by the block_translation_array
  } mat_resp_t;

  typedef struct packed {
    logic [33:0] tag;
    logic [19:0] rpn;
    logic [1:0]  pp;
    logic        g;
    logic        c;
    logic [31:0] pte_addr;
  } mat_tlbe_t;
endpackage

// [sim/mat_top_checker.sv]
// Purpose: Port-level checks of the address translation block
// Assumes: One clock, synchronous active-low reset, enables changed only while idle
// Notes:   Relocation enables are mirrored from APB writes to the control word
`timescale 1ns/1ps
module mat_top_checker
  import mat_pkg::*;
(
  input wire logic        clk_sys_in,     // Clock
  input wire logic        rst_n_in,       // Reset, active low
  input wire logic        psel_in,        // APB select
  input wire logic        penable_in,     // APB access phase
  input wire logic        pwrite_in,      // APB write
  input wire logic [11:0] paddr_in,       // APB address
  input wire logic [31:0] pwdata_in,      // APB write data
  input wire logic        pready_out,     // APB ready
  input wire logic [1:0]  req_valid_in,   // Request valid
  input mat_req_t         req_in [2],     // Requests
  input wire logic [1:0]  req_ready_out,  // Request ready
  input wire logic [1:0]  resp_valid_out, // Answer strobe
  input mat_resp_t        resp_out [2],   // Answers
  input wire logic        mem_req_out,    // Table request
  input wire logic        mem_we_out,     // Table write
  input wire logic [31:0] mem_addr_out,   // Table address
  input wire logic [31:0] mem_wdata_out,  // Table write data
  input wire logic        mem_ack_in      // Table done
);
  logic [1:0]  ctrl_q; // Enables as last written
  logic [31:0] ea_q [2]; // Address in flight per side
  // Mirror of the enables; a write mid-request would confuse the real-mode checks
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) ctrl_q <= 2'h0;
    else if (psel_in && penable_in && pwrite_in && paddr_in == MAT_CTRL_OFS) ctrl_q <= pwdata_in[1:0];
  end
  // Address capture at acceptance
  always_ff @(posedge clk_sys_in) begin
    for (int s = 0; s < 2; s++) if (req_valid_in[s] && req_ready_out[s]) ea_q[s] <= req_in[s].ea;
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_take_i; req_valid_in[0] && req_ready_out[0]; endsequence
  sequence s_take_d; req_valid_in[1] && req_ready_out[1]; endsequence
  sequence s_real_i; ##2 resp_valid_out[0] && resp_out[0].pa == $past(req_in[0].ea, 2) && resp_out[0].exc == MAT_OK;
  endsequence
  sequence s_real_d; ##2 resp_valid_out[1] && resp_out[1].pa == $past(req_in[1].ea, 2) && resp_out[1].exc == MAT_OK;
  endsequence
  sequence s_mem_wait; mem_req_out && !mem_ack_in; endsequence
  a_apb_zero_wait: assert property (psel_in && penable_in |-> pready_out) else $error("APB access not ready");
  a_real_fetch: assert property (s_take_i ##0 !ctrl_q[0] |-> s_real_i) else $error("fetch real mode wrong");
  a_real_data: assert property (s_take_d ##0 !ctrl_q[1] |-> s_real_d) else $error("data real mode wrong");
  a_one_outstanding: assert property (s_take_d |=> !req_ready_out[1]) else $error("data side took twice");
  a_page_offset: assert property (resp_valid_out[1] && resp_out[1].exc == MAT_OK
    |-> resp_out[1].pa[11:0] == ea_q[1][11:0]) else $error("page offset changed");
  a_block_offset: assert property (resp_valid_out[1] && resp_out[1].block
    |-> resp_out[1].pa[16:0] == ea_q[1][16:0]) else $error("block offset changed");
  a_noexec_data: assert property (resp_valid_out[1] |-> resp_out[1].exc != MAT_NOEXEC)
    else $error("no-execute on data");
  a_mem_hold: assert property (s_mem_wait |=> mem_req_out && $stable(mem_addr_out) && $stable(mem_we_out)
    && $stable(mem_wdata_out)) else $error("table request moved");
  a_mem_release: assert property (mem_req_out && mem_ack_in |=> !mem_req_out) else $error("table request held");
  a_resp_pulse: assert property (resp_valid_out[0] |=> !resp_valid_out[0]) else $error("answer longer than a cycle");
endmodule
bind mat_top mat_top_checker mat_top_checker_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pready_out(pready_out), .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
  .resp_valid_out(resp_valid_out), .resp_out(resp_out), .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
  .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .mem_ack_in(mem_ack_in));

// [sim/mat_mem_model.sv]
// Purpose: Table memory on the far side of the walker port
// Assumes: One access at a time, acknowledged after lat_in extra cycles
// Notes:   Unwritten words read as zero, an invalid table entry
`timescale 1ns/1ps
module mat_mem_model (
  input wire logic        clk_sys_in,    // Clock
  input wire logic        mem_req_in,    // Access request
  input wire logic        mem_we_in,     // Write
  input wire logic [31:0] mem_addr_in,   // Word address
  input wire logic [31:0] mem_wdata_in,  // Write data
  input wire logic [2:0]  lat_in,        // Extra wait cycles
  output logic            mem_ack_out,   // One-cycle done
  output logic     [31:0] mem_rdata_out  // Read data
);
  logic [31:0] mem [logic [31:0]]; // Sparse table storage
  logic [31:0] data_q = 32'h0;
  logic [2:0]  cnt_q = 3'h0;
  logic        ack_q = 1'b0;
  // Wait, then answer once; no answer while the last ack is still visible
  always @(posedge clk_sys_in) begin
    if (ack_q) begin
      ack_q <= 1'b0;
      cnt_q <= 3'h0;
    end else if (mem_req_in && cnt_q >= lat_in) begin
      ack_q <= 1'b1;
      if (mem_we_in) mem[mem_addr_in] = mem_wdata_in;
      data_q <= mem.exists(mem_addr_in) ? mem[mem_addr_in] : 32'h0;
    end else if (mem_req_in) cnt_q <= cnt_q + 3'h1;
  end
  // Data line shows the inverse of the last word outside an answer
  assign mem_ack_out = ack_q;
  assign mem_rdata_out = ack_q ? data_q : ~data_q;
endmodule

// [sim/test_mat_top.sv]
// Purpose: Self-checking bench for the address translation block
// Assumes: Page table at address zero, primary hash only
// Notes:   Random addresses and memory latency from a fixed seed
`timescale 1ns/1ps
module test_mat_top;
  import mat_pkg::*;
  logic        clk_sys_in = 1'b0, rst_n_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, ea, mem_addr, mem_wdata, mem_rdata;
  logic        er, pready, pslverr, mem_req, mem_we, mem_ack;
  logic [1:0]  vld = 2'h0, rdy, rvld;
  logic [2:0]  lat = 3'h0;
  mat_req_t    req [2] = '{default: '0};
  mat_resp_t   resp [2], r;
  logic [43:0] cfg [9] = '{{MAT_SEG_OFS + 12'h004, 32'h2000_0005}, {MAT_SEG_OFS + 12'h008, 32'h8000_0000},
    {MAT_SEG_OFS + 12'h00c, 32'h1000_0005}, {MAT_BAT_OFS + 12'h020, 32'h4000_0003},
    {MAT_BAT_OFS + 12'h024, 32'h8002_0001}, {MAT_BAT_OFS + 12'h028, 32'h5000_0003},
    {MAT_BAT_OFS + 12'h02c, 32'h5000_000a}, {MAT_CTRL_OFS, 32'h0000_0001}, {MAT_CTRL_OFS, 32'h0000_0003}};
  int          num_errors = 0, n_checks = 0, cyc = 0;
  mat_top mat_top_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(rd),
    .pslverr_out(pslverr), .req_valid_in(vld), .req_in(req), .req_ready_out(rdy), .resp_valid_out(rvld),
    .resp_out(resp), .mem_req_out(mem_req), .mem_we_out(mem_we), .mem_addr_out(mem_addr),
    .mem_wdata_out(mem_wdata), .mem_ack_in(mem_ack), .mem_rdata_in(mem_rdata));
  mat_mem_model mat_mem_model_inst (.clk_sys_in(clk_sys_in), .mem_req_in(mem_req), .mem_we_in(mem_we),
    .mem_addr_in(mem_addr), .mem_wdata_in(mem_wdata), .lat_in(lat), .mem_ack_out(mem_ack),
    .mem_rdata_out(mem_rdata));
  // 50 ns period
  always #25 clk_sys_in = ~clk_sys_in;
  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  function automatic logic [31:0] merge(logic [31:0] base, logic [31:0] a, logic [31:0] m);
    return (base & ~m) | (a & m);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkx(input mat_exc_t g, input mat_exc_t e);
    chk(g, e);
  endtask
  // One APB transfer; an idle edge after it keeps strobes single-driven per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys_in) penable <= 1'b1;
    do @(posedge clk_sys_in); while (pready !== 1'b1);
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  // One translation request, f = {user, store, spec}
  task automatic acc(input int s, input logic [31:0] a, input logic [2:0] f);
    req[s] <= {a, f}; vld[s] <= 1'b1; lat <= 3'($urandom_range(3));
    do @(posedge clk_sys_in); while (rdy[s] !== 1'b1);
    vld[s] <= 1'b0;
    do @(posedge clk_sys_in); while (rvld[s] !== 1'b1);
    r = resp[s];
    @(posedge clk_sys_in);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(2776));
    mat_mem_model_inst.mem[32'h0000_d000] = 32'h8000_0288;
    mat_mem_model_inst.mem[32'h0000_d004] = 32'habcd_e008;
    repeat (6) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    apb(1'b0, MAT_CTRL_OFS, 32'h0); chk(rd, {30'h0, MAT_CTRL_RST}); chk(er, 32'h0);
    apb(1'b0, 12'hff0, 32'h0); chk(er, 32'h1);
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, cfg[i][43:32], cfg[i][31:0]);
      if (i == 7) begin
        ea = $urandom; acc(1, ea, {1'b0, 2'($urandom)}); chk(r.pa, ea); chkx(r.exc, MAT_OK);
      end
      if (i > 6) continue;
      for (int j = 0; j < 2; j++) begin
        ea = $urandom; acc(j, ea, {1'b1, 1'(j), 1'b0}); chk(r.pa, ea); chkx(r.exc, MAT_OK);
      end
    end
    for (int i = 0; i < 4; i++) begin
      ea = 32'h4000_0000 | ($urandom & 32'h0001_ffff);
      acc(1, ea, {ea[5:4], 1'b0}); chk(r.pa, merge(32'h8002_0000, ea, 32'h1ffff)); chk(r.block, 1);
      chkx(r.exc, ea[4] ? MAT_PROT : MAT_OK);
    end
    acc(0, ea, 3'h0); chkx(r.exc, MAT_PAGE_FAULT);
    acc(1, 32'h1234_5678, 3'h0); chk(r.pa, 32'habcd_e678); chkx(r.exc, MAT_OK);
    chk(mat_mem_model_inst.mem[32'h0000_d004], 32'habcd_e108);
    acc(1, 32'h1234_5abc, 3'h2); chk(r.pa, 32'habcd_eabc);
    chk(mat_mem_model_inst.mem[32'h0000_d004], 32'habcd_e188);
    acc(1, 32'h1234_5000, 3'h4); chkx(r.exc, MAT_PROT);
    acc(0, 32'h1234_5010, 3'h0); chk(r.pa, 32'habcd_e010); chkx(r.exc, MAT_GUARD);
    for (int j = 0; j < 2; j++) begin
      acc(j, 32'h1234_0000, 3'h0); chkx(r.exc, MAT_PAGE_FAULT);
      acc(j, 32'h2000_0100, 3'h0); chkx(r.exc, MAT_DSTORE);
      acc(j, 32'h3000_0000, 3'h0); chkx(r.exc, j ? MAT_PAGE_FAULT : MAT_NOEXEC);
    end
    acc(1, 32'h5000_0040, 3'h1); chkx(r.exc, MAT_DEFER);
    acc(1, 32'h5000_0040, 3'h0); chkx(r.exc, MAT_OK); chk(r.pa, 32'h5000_0040);
    results();
  end
endmodule
